// [core/float_subtract_op.sv]
// Floating-point subtract unit with parallel word move, reached over APB.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Decode immediate form from fixed prefix.
// - Immediate fills upper half, low zero.
// - Immediate minus source into destination.
// - Result written two stages after issue.
// - Latch under/overflow; other flags kept.
// - Decode load form selectors from prefix.
// - Subtract and load memory word together.
// - Loaded word sets sign and zero flags.
// - Move completes one slot before result.
// - Store form writes source word out.
module float_subtract_op #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic store_valid,
  output logic [31:0] store_data
);

  if (ADDR_W != 8)
  begin : g_bad_addr
    $error("float_subtract_op serves an 8-bit APB address only.");
  end

  fsub_pkg::state_s st_q;
  fsub_pkg::state_s st_d;
  fsub_pkg::stage1_s iss;
  logic wr;
  logic issue;
  logic stat_wr;
  logic [33:0] sub_r;

  // Returns {overflow, underflow, result}; denormal inputs count as zero, rounding truncates.
  function automatic logic [33:0] fsub(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] nb;
    logic [26:0] mx;
    logic [26:0] my;
    logic [26:0] s;
    logic [26:0] sh;
    logic [7:0] dd;
    logic signed [9:0] e;
    logic found;
    int lz;
    nb = {~b[31], b[30:0]};
    if (nb[30:0] > a[30:0])
    begin
      x = nb;
      y = a;
    end
    else
    begin
      x = a;
      y = nb;
    end
    mx = (x[30:23] == 8'h00) ? 27'h000_0000 : {2'b01, x[22:0], 2'b00};
    my = (y[30:23] == 8'h00) ? 27'h000_0000 : {2'b01, y[22:0], 2'b00};
    dd = x[30:23] - y[30:23];
    my = (dd > 8'h1A) ? 27'h000_0000 : my >> dd;
    s = (x[31] == y[31]) ? mx + my : mx - my;
    lz = 0;
    found = 1'b0;
    for (int i = 0; i < 26; i++)
    begin
      if (!found && s[25-i])
      begin
        found = 1'b1;
        lz = i;
      end
    end
    sh = s << lz;
    if (s[26])
    begin
      e = $signed({2'b00, x[30:23]}) + 10'sd1;
      sh = s >> 1;
    end
    else
    begin
      e = $signed({2'b00, x[30:23]}) - $signed(10'(lz));
    end
    if (s == 27'h000_0000)
      fsub = {2'b00, fsub_pkg::WORD_ZERO};
    else if (e >= $signed({2'b00, fsub_pkg::EXP_MAX}))
      fsub = {2'b10, x[31], fsub_pkg::EXP_MAX, 23'h00_0000};
    else if (e <= 10'sd0)
      fsub = {2'b01, x[31], 31'h0000_0000};
    else
      fsub = {2'b00, x[31], e[7:0], sh[24:2]};
  endfunction : fsub

  // Operand read with bypass of a result that retires at the same edge as the issue.
  function automatic logic [31:0] rdreg(input fsub_pkg::state_s s, input logic [2:0] i);
    if (s.s2.valid && s.s2.dst == i)
      rdreg = s.s2.res;
    else
      rdreg = s.fpr[i];
  endfunction : rdreg

  assign wr = psel && penable && pwrite;
  assign issue = wr && paddr == fsub_pkg::OFF_INSN_HI;
  assign stat_wr = wr && paddr == fsub_pkg::OFF_STATUS;
  assign sub_r = fsub(st_q.s1.mina, st_q.s1.subb);

  // Decode of the instruction formed by the latched low word and the written high word.
  always_comb
  begin
    iss = '0;
    iss.kind = fsub_pkg::OP_NONE;
    if (st_q.insn_lo[15:6] == fsub_pkg::IMM_PREFIX)
    begin
      iss.kind = fsub_pkg::OP_IMM;
      iss.dst = pwdata[2:0];
      iss.mina = {st_q.insn_lo[5:0], pwdata[15:6], 16'h0000};
      iss.subb = rdreg(st_q, pwdata[5:3]);
    end
    else if (st_q.insn_lo[15:4] == fsub_pkg::LOAD_PREFIX ||
             st_q.insn_lo[15:4] == fsub_pkg::STORE_PREFIX)
    begin
      iss.kind = (st_q.insn_lo[15:4] == fsub_pkg::LOAD_PREFIX) ?
                 fsub_pkg::OP_LOAD : fsub_pkg::OP_STORE;
      iss.subb = rdreg(st_q, st_q.insn_lo[3:1]);
      iss.mina = rdreg(st_q, {st_q.insn_lo[0], pwdata[15:14]});
      iss.dst = pwdata[13:11];
      iss.mov = pwdata[10:8];
      iss.mdata = (iss.kind == fsub_pkg::OP_LOAD) ?
                  st_q.load_word : rdreg(st_q, pwdata[10:8]);
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.store_valid = 1'b0;
    st_d.s1.kind = fsub_pkg::OP_NONE;
    st_d.s2.valid = 1'b0;
    if (st_q.s2.valid)
      st_d.fpr[st_q.s2.dst] = st_q.s2.res;
    if (stat_wr)
      st_d.flags = pwdata[fsub_pkg::FLAG_W-1:0];
    // Hardware events are applied after the flag write so that a set always wins.
    if (st_q.s2.valid)
    begin
      st_d.flags[fsub_pkg::LAT_UDF_BIT] |= st_q.s2.uf;
      st_d.flags[fsub_pkg::LAT_OVF_BIT] |= st_q.s2.ov;
    end
    if (st_q.s1.kind != fsub_pkg::OP_NONE)
    begin
      st_d.s2.valid = 1'b1;
      st_d.s2.dst = st_q.s1.dst;
      st_d.s2.res = sub_r[31:0];
      st_d.s2.uf = sub_r[32];
      st_d.s2.ov = sub_r[33];
      if (st_q.s1.kind == fsub_pkg::OP_LOAD)
      begin
        st_d.fpr[st_q.s1.mov] = st_q.s1.mdata;
        st_d.flags[fsub_pkg::FNEG_BIT] = st_q.s1.mdata[31];
        st_d.flags[fsub_pkg::INEG_BIT] = st_q.s1.mdata[31];
        st_d.flags[fsub_pkg::FZERO_BIT] = st_q.s1.mdata[30:23] == 8'h00;
        if (st_q.s1.mdata[30:23] == 8'h00)
          st_d.flags[fsub_pkg::FNEG_BIT] = 1'b0;
        st_d.flags[fsub_pkg::IZERO_BIT] = st_q.s1.mdata == fsub_pkg::WORD_ZERO;
      end
      if (st_q.s1.kind == fsub_pkg::OP_STORE)
      begin
        st_d.store_valid = 1'b1;
        st_d.store_word = st_q.s1.mdata;
      end
    end
    if (wr)
    begin
      case (paddr)
        fsub_pkg::OFF_INSN_LO: st_d.insn_lo = pwdata[15:0];
        fsub_pkg::OFF_INSN_HI: st_d.s1 = iss;
        fsub_pkg::OFF_LOAD_WORD: st_d.load_word = pwdata;
        default:
        begin
          if (paddr[7:5] == fsub_pkg::OFF_FPR_BASE[7:5] && paddr[1:0] == 2'b00)
            st_d.fpr[paddr[4:2]] = pwdata;
        end
      endcase
    end
    // Read data and the error answer are prepared in the setup cycle for a zero-wait access.
    if (psel && !penable)
    begin
      st_d.pslverr = 1'b0;
      st_d.prdata = fsub_pkg::WORD_ZERO;
      case (paddr)
        fsub_pkg::OFF_INSN_LO: st_d.prdata = {16'h0000, st_q.insn_lo};
        fsub_pkg::OFF_INSN_HI: st_d.prdata = fsub_pkg::WORD_ZERO;
        fsub_pkg::OFF_LOAD_WORD: st_d.prdata = st_q.load_word;
        fsub_pkg::OFF_STORE_WORD: st_d.prdata = st_q.store_word;
        fsub_pkg::OFF_STATUS: st_d.prdata = {25'h000_0000, st_q.flags};
        default:
        begin
          if (paddr[7:5] == fsub_pkg::OFF_FPR_BASE[7:5] && paddr[1:0] == 2'b00)
            st_d.prdata = st_q.fpr[paddr[4:2]];
          else
            st_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.flags <= fsub_pkg::STATUS_RST;
      st_q.s1.kind <= fsub_pkg::OP_NONE;
    end
    else
      st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = 1'b1;
  assign pslverr = st_q.pslverr && psel && penable;
  assign store_valid = st_q.store_valid;
  assign store_data = st_q.store_word;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_issue;
    issue && iss.kind != fsub_pkg::OP_NONE;
  endsequence

  sequence s_pipe;
    st_q.s1.kind != fsub_pkg::OP_NONE ##1 st_q.s2.valid;
  endsequence

  AST_IMM_DECODE: assert property (issue && st_q.insn_lo[15:6] == fsub_pkg::IMM_PREFIX |=>
    st_q.s1.kind == fsub_pkg::OP_IMM && st_q.s1.dst == $past(pwdata[2:0]))
    else $error("Immediate form not decoded.");
  AST_IMM_EXPAND: assert property (st_q.s1.kind == fsub_pkg::OP_IMM |->
    st_q.s1.mina[15:0] == 16'h0000)
    else $error("Immediate low half not zero.");
  AST_TWO_STAGE: assert property (s_issue |=> s_pipe ##1
    st_q.fpr[$past(st_q.s2.dst)] == $past(st_q.s2.res))
    else $error("Result not written two stages after issue.");
  AST_LATCH_FLAGS: assert property (st_q.s2.valid && st_q.s2.uf |=>
    st_q.flags[fsub_pkg::LAT_UDF_BIT])
    else $error("Underflow not latched.");
  AST_KEEP_FLAGS: assert property (st_q.s1.kind == fsub_pkg::OP_IMM && !stat_wr |=>
    st_q.flags[6:2] == $past(st_q.flags[6:2]))
    else $error("Immediate form changed sign or zero flags.");
  AST_LOAD_DECODE: assert property (issue && st_q.insn_lo[15:4] == fsub_pkg::LOAD_PREFIX |=>
    st_q.s1.kind == fsub_pkg::OP_LOAD && st_q.s1.mov == $past(pwdata[10:8]))
    else $error("Load form not decoded.");
  AST_LOAD_MOVE: assert property (st_q.s1.kind == fsub_pkg::OP_LOAD |=>
    st_q.fpr[$past(st_q.s1.mov)] == $past(st_q.s1.mdata) && st_q.s2.valid)
    else $error("Load word not moved one slot early.");
  AST_LOAD_FLAGS: assert property (st_q.s1.kind == fsub_pkg::OP_LOAD |=>
    st_q.flags[fsub_pkg::IZERO_BIT] == ($past(st_q.s1.mdata) == fsub_pkg::WORD_ZERO) &&
    st_q.flags[fsub_pkg::INEG_BIT] == $past(st_q.s1.mdata[31]))
    else $error("Load flags wrong.");
  AST_STORE: assert property (st_q.s1.kind == fsub_pkg::OP_STORE |=>
    store_valid && store_data == $past(st_q.s1.mdata))
    else $error("Store word not driven.");
  AST_STICKY: assert property (st_q.flags[fsub_pkg::LAT_OVF_BIT] && !stat_wr |=>
    st_q.flags[fsub_pkg::LAT_OVF_BIT])
    else $error("Latched overflow cleared without flag write.");

endmodule : float_subtract_op

`default_nettype wire

// [core/fsub_pkg.sv]
// Package with offsets, opcode prefixes, flag layout and state types of the subtract unit.
package fsub_pkg;
  localparam logic [7:0] OFF_INSN_LO = 8'h00;
  localparam logic [7:0] OFF_INSN_HI = 8'h04;
  localparam logic [7:0] OFF_LOAD_WORD = 8'h08;
  localparam logic [7:0] OFF_STORE_WORD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_FPR_BASE = 8'h20;
  localparam logic [9:0] IMM_PREFIX = 10'h3A3;
  localparam logic [11:0] LOAD_PREFIX = 12'hE32;
  localparam logic [11:0] STORE_PREFIX = 12'hE02;
  localparam int FLAG_W = 7;
  localparam int LAT_OVF_BIT = 0;
  localparam int LAT_UDF_BIT = 1;
  localparam int FNEG_BIT = 2;
  localparam int FZERO_BIT = 3;
  localparam int INEG_BIT = 4;
  localparam int IZERO_BIT = 5;
  localparam int TEST_BIT = 6;
  localparam logic [6:0] STATUS_RST = 7'h00;
  localparam logic [7:0] EXP_MAX = 8'hFF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {OP_NONE, OP_IMM, OP_LOAD, OP_STORE} op_kind_e;

  typedef struct packed {
    op_kind_e kind;
    logic [2:0] dst;
    logic [2:0] mov;
    logic [31:0] mina;
    logic [31:0] subb;
    logic [31:0] mdata;
  } stage1_s;

  typedef struct packed {
    logic valid;
    logic [2:0] dst;
    logic [31:0] res;
    logic uf;
    logic ov;
  } stage2_s;

  typedef struct packed {
    logic [7:0][31:0] fpr;
    logic [6:0] flags;
    logic [15:0] insn_lo;
    logic [31:0] load_word;
    logic [31:0] store_word;
    logic store_valid;
    stage1_s s1;
    stage2_s s2;
    logic [31:0] prdata;
    logic pslverr;
  } state_s;
endpackage : fsub_pkg

// [verif/data_mem_model.sv]
// Memory-side model that takes the words written out by the store form.
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic store_valid,
  input wire logic [31:0] store_data,
  output logic [31:0] last_word,
  output int n_stores
);
  // The pulse stands for one edge only, so a missed edge loses the store.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_word <= 32'h0000_0000;
      n_stores <= 0;
    end
    else if (store_valid)
    begin
      last_word <= store_data;
      n_stores <= n_stores + 1;
    end
  end
endmodule : data_mem_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the subtract unit with parallel word move.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, store_valid, rd_e;
  logic [31:0] prdata, store_data, last_word, rd_v;
  int n_stores;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] src_v [4] = '{32'h3F80_0000, 32'hFF00_0000, 32'h0080_0001, 32'h3F80_0000};
  logic [15:0] imm_v [4] = '{16'h4000, 16'h7F00, 16'h0080, 16'h4000};
  logic [31:0] res_v [4] = '{32'h3F80_0000, 32'h7F80_0000, 32'h8000_0000, 32'h3F80_0000};
  logic [31:0] st_v [4] = '{32'h0000_007C, 32'h0000_007D, 32'h0000_007F, 32'h0000_007F};
  logic [31:0] ld_v [4] = '{32'h8000_0000, 32'h0000_0000, 32'hC000_0000, 32'h3F80_0000};

  always #2 pclk = ~pclk;

  float_subtract_op #(.ADDR_W(8)) float_subtract_op_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .store_valid(store_valid),
    .store_data(store_data));
  data_mem_model data_mem_model_inst (.pclk(pclk), .presetn(presetn),
    .store_valid(store_valid), .store_data(store_data), .last_word(last_word),
    .n_stores(n_stores));

  task automatic test_done;
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      fails = fails + 1;
    end
  endtask : check

  // The request holds until pready is seen high; only the timeout ends the wait.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(name, rd_v, exp);
  endtask : rd_chk

  function automatic logic [7:0] fpr(input logic [2:0] i);
    return fsub_pkg::OFF_FPR_BASE + {3'b000, i, 2'b00};
  endfunction : fpr

  function automatic logic [31:0] mv_flags(input logic [31:0] w);
    logic [31:0] f;
    f = 32'h0000_0000;
    f[fsub_pkg::FNEG_BIT] = w[31];
    if (w[30:23] == 8'h00)
    begin
      f[fsub_pkg::FZERO_BIT] = 1'b1;
      f[fsub_pkg::FNEG_BIT] = 1'b0;
    end
    f[fsub_pkg::INEG_BIT] = w[31];
    f[fsub_pkg::IZERO_BIT] = (w == 32'h0000_0000);
    return f;
  endfunction : mv_flags

  task automatic issue(input logic [15:0] lo, input logic [15:0] hi);
    apb(1'b1, fsub_pkg::OFF_INSN_LO, {16'h0000, lo});
    apb(1'b1, fsub_pkg::OFF_INSN_HI, {16'h0000, hi});
  endtask : issue

  // Selector e straddles the two words, so e values with bit 2 set are used.
  task automatic par(input logic [11:0] pre, input logic [2:0] e, f, d, a);
    issue({pre, f, e[2]}, {e[1:0], d, a, 8'h00});
  endtask : par

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, fsub_pkg::OFF_STATUS, 32'h0000_007C);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, fpr(3'd1), src_v[i]);
      issue({fsub_pkg::IMM_PREFIX, imm_v[i][15:10]}, {imm_v[i][9:0], 3'd1, 3'd2});
      // The delay slot passes untouched, so the read sees the retired result.
      @(posedge pclk);
      rd_chk("imm result", fpr(3'd2), res_v[i]);
      rd_chk("imm status", fsub_pkg::OFF_STATUS, st_v[i]);
    end
    apb(1'b1, fsub_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk("cleared status", fsub_pkg::OFF_STATUS, 32'h0000_0000);
    apb(1'b1, fpr(3'd4), 32'h4040_0000);
    apb(1'b1, fpr(3'd3), 32'h3F80_0000);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, fsub_pkg::OFF_LOAD_WORD, ld_v[i]);
      par(fsub_pkg::LOAD_PREFIX, 3'd4, 3'd3, 3'd5, 3'd6);
      @(posedge pclk);
      rd_chk("loaded reg", fpr(3'd6), ld_v[i]);
      rd_chk("load result", fpr(3'd5), 32'h4000_0000);
      rd_chk("load status", fsub_pkg::OFF_STATUS, mv_flags(ld_v[i]));
    end
    apb(1'b1, fsub_pkg::OFF_STATUS, 32'h0000_002A);
    apb(1'b1, fpr(3'd7), 32'h1234_5678);
    par(fsub_pkg::STORE_PREFIX, 3'd4, 3'd3, 3'd1, 3'd7);
    @(posedge pclk);
    #1;
    check("store pulse", {31'h0, store_valid}, 32'h0000_0001);
    check("store data", store_data, 32'h1234_5678);
    @(posedge pclk);
    #1;
    check("store pulse end", {31'h0, store_valid}, 32'h0000_0000);
    check("memory word", last_word, 32'h1234_5678);
    check("store count", n_stores, 32'h0000_0001);
    rd_chk("store result", fpr(3'd1), 32'h4000_0000);
    rd_chk("store status", fsub_pkg::OFF_STATUS, 32'h0000_002A);
    rd_chk("stored word reg", fsub_pkg::OFF_STORE_WORD, 32'h1234_5678);
    apb(1'b0, 8'h14, 32'h0000_0000);
    check("unmapped error", {31'h0, rd_e}, 32'h0000_0001);
    test_done();
  end
endmodule : tb
`default_nettype wire
